/* common/icu_defines.svh */
/*
 * Constants of the input conditioning unit: widths, reset values, timing.
 * Assumes a 100 MHz reference clock; included by the package only.
 */
`ifndef ICU_DEFINES_SVH
`define ICU_DEFINES_SVH

`define ICU_NIN            16
`define ICU_NGRP           4
`define ICU_GRP_SZ         4
`define ICU_DSEL_W         3
`define ICU_DSEL_RST       3'h5
`define ICU_DSEL_MAX       3'h6
`define ICU_DF_MIN_TIME_NS 200000
`define ICU_DF_MAX_TIME_NS 12800000
`define ICU_CLK_PERIOD_NS  10
`define ICU_DF_MIN_CYC     (`ICU_DF_MIN_TIME_NS / `ICU_CLK_PERIOD_NS)
`define ICU_DCNT_W         21
`define ICU_NAN            4
`define ICU_ACH_W          2
`define ICU_AW             16
`define ICU_SCODE_W        3
`define ICU_SCODE_RST      3'h4
`define ICU_SCODE_MAX      3'h6
`define ICU_HPTR_W         6
`define ICU_FILL_W         7
`define ICU_SUM_W          22
`define ICU_DB_RST         16'h0040
`define ICU_AF_EN_RST      4'hc
`define ICU_MEM_AW         8
`define ICU_MEM_DEPTH      256

`endif

/* common/icu_pkg.sv */
/*
 * Types of the input conditioning unit.
 * Assumes icu_defines.svh on the include path.
 */
`include "icu_defines.svh"

package icu_pkg;

    typedef logic [`ICU_NIN-1:0] icu_din_t;
    typedef logic [`ICU_AW-1:0]  icu_aword_t;
    typedef icu_aword_t [`ICU_NAN-1:0] icu_aimg_t;

    typedef struct packed {
        logic [`ICU_NGRP-1:0][`ICU_DSEL_W-1:0] dsel;
        logic [`ICU_NIN-1:0]                   pc_en;
        logic [`ICU_NAN-1:0]                   af_en;
        logic [`ICU_SCODE_W-1:0]               scode;
        icu_aword_t                            deadband;
    } icu_cfg_t;

    typedef struct packed {
        logic [`ICU_SUM_W-1:0]  sum;
        icu_aword_t             seed;
        icu_aword_t             filt;
        logic [`ICU_FILL_W-1:0] fill;
        logic [`ICU_HPTR_W-1:0] ptr;
    } icu_ach_t;

    typedef enum logic [1:0] {
        A_IDLE,
        A_READ,
        A_CALC
    } icu_astate_t;

    typedef struct packed {
        icu_din_t                              s1;
        icu_din_t                              s2;
        icu_din_t                              s3;
        icu_din_t                              raw;
        icu_din_t                              filt;
        logic [`ICU_NIN-1:0][`ICU_DCNT_W-1:0]  cnt;
        icu_din_t                              latched;
        icu_din_t                              cval;
        icu_din_t                              image;
        icu_cfg_t                              cfg;
        icu_astate_t                           astate;
        logic                                  ready;
        logic [`ICU_ACH_W-1:0]                 cur_ch;
        icu_aword_t                            cur_data;
        icu_ach_t [`ICU_NAN-1:0]               ach;
        icu_aimg_t                             aimg;
    } icu_state_t;

endpackage : icu_pkg

/* hw/icu_hist_mem.sv */
/*
 * Sample history memory for the analog averaging filter.
 * Assumes one clock; read data appear one edge after the address.
 */
module icu_hist_mem
    import icu_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   we,
    input  wire logic [`ICU_MEM_AW-1:0] waddr,
    input  wire icu_aword_t             wdata,
    input  wire logic [`ICU_MEM_AW-1:0] raddr,
    output icu_aword_t                  rdata_q
);
    icu_aword_t mem [`ICU_MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : icu_hist_mem

/* hw/icu_top.sv */
/*
 * Input conditioning unit: digital delay filter, pulse catch, scan image,
 * analog averaging filter with deadband step.
 * Assumes DIN from field pins, all other inputs on REF_CLK.
 */
//   Function
// (RL1) Each digital input delayed by a selectable 0.2 ms to 12.8 ms filter.
// (RL2) Filter delay defaults to 6.4 ms until a setting is loaded.
// (RL3) One delay setting per group of inputs, shared by its points.
// (RL4) Filtered value feeds program reads, edge interrupts and pulse catch.
// (RL5) High speed counters see unfiltered inputs.
// (RL6) Enabled pulse catch latches a change until the next scan sample.
// (RL7) Both high-going and low-going short pulses are caught.
// (RL8) Per-input pulse catch enable; disabled inputs pass filtered value.
// (RL9) Pulse catch follows the delay filter.
// (RL10) Only the first pulse within one scan is captured.
// (RL11) Analog filtering enabled separately per analog word.
// (RL12) Enabled analog word outputs average of the latest configured samples.
// (RL13) Sample count and deadband shared by all filtered analog words.
// (RL14) Change beyond deadband steps output straight to the latest sample.
// (RL15) Deadband compared in converted counts.
// (RL16) Analog filtering on by default except the two on-board words.
// (RL17) Digital inputs sampled once at each scan start.
// (RL18) All inputs captured together at scan start and frozen for the scan.
// (RL19) Filter output changes only after the new level held the full delay.
// (RL20) Pulse catch latch clears and re-arms when the scan sampler reads it.
module icu_top
    import icu_pkg::*;
#(
    parameter int DF_MIN_CYC = `ICU_DF_MIN_CYC
) (
    input  wire logic         REF_CLK,
    input  wire logic         RESET_N,
    input  wire icu_din_t     DIN,
    input  wire logic         SCAN_START,
    input  wire logic         CFG_LOAD,
    input  wire icu_cfg_t     CFG,
    input  wire logic         AN_VALID,
    input  wire logic [1:0]   AN_CHAN,
    input  wire icu_aword_t   AN_DATA,
    output logic              AN_READY,
    output icu_din_t          DIN_IMAGE,
    output icu_din_t          DIN_FILT,
    output icu_din_t          HSC_RAW,
    output icu_aimg_t         AN_IMAGE,
    output icu_cfg_t          CFG_ACTIVE
);
    logic                   rst_s1_q;
    logic                   rst_n_q;
    icu_state_t             q;
    icu_state_t             d;
    icu_aword_t             mem_rdata;
    logic                   mem_we;
    logic [`ICU_MEM_AW-1:0] mem_waddr;
    logic [`ICU_MEM_AW-1:0] mem_raddr;

    // Filter delay in cycles for a code
    function automatic logic [`ICU_DCNT_W-1:0] dly_cyc(input logic [`ICU_DSEL_W-1:0] c);
        logic [`ICU_DSEL_W-1:0] cc;
        cc = (c > `ICU_DSEL_MAX) ? `ICU_DSEL_MAX : c;
        return `ICU_DCNT_W'(DF_MIN_CYC) << cc;
    endfunction : dly_cyc

    // Running sum of a uniform history
    function automatic logic [`ICU_SUM_W-1:0] seed_sum(input icu_aword_t v,
                                                      input logic [`ICU_SCODE_W-1:0] k);
        return `ICU_SUM_W'(v) << k;
    endfunction : seed_sum

    // Distance of two sample counts
    function automatic icu_aword_t abs_diff(input icu_aword_t a,
                                            input icu_aword_t b);
        return (a > b) ? a - b : b - a;
    endfunction : abs_diff

    // Sample count code limited to 6 (64 samples)
    function automatic logic [`ICU_SCODE_W-1:0] clamp_k(input logic [`ICU_SCODE_W-1:0] k);
        return (k > `ICU_SCODE_MAX) ? `ICU_SCODE_MAX : k;
    endfunction : clamp_k

    // Configuration after reset
    function automatic icu_cfg_t cfg_rst();
        icu_cfg_t c;
        c          = '0;
        c.dsel     = {`ICU_NGRP{`ICU_DSEL_RST}};
        c.af_en    = `ICU_AF_EN_RST;
        c.scode    = `ICU_SCODE_RST;
        c.deadband = `ICU_DB_RST;
        return c;
    endfunction : cfg_rst

    // Pins that agree on two flops
    function automatic icu_din_t sync_agree(input icu_din_t s2,
                                            input icu_din_t s3,
                                            input icu_din_t held);
        icu_din_t r;
        r = held;
        for (int i = 0; i < `ICU_NIN; i++) begin
            if (s2[i] == s3[i]) begin
                r[i] = s3[i];
            end
        end
        return r;
    endfunction : sync_agree

    // Fresh catches on the filtered level
    function automatic icu_din_t pc_hit(input icu_din_t en,
                                        input icu_din_t held,
                                        input icu_din_t lvl,
                                        input icu_din_t img);
        return en & ~held & (lvl ^ img);
    endfunction : pc_hit

    // Level handed to the scan sampler
    function automatic icu_din_t pc_view(input icu_din_t en,
                                         input icu_din_t held,
                                         input icu_din_t cval,
                                         input icu_din_t lvl);
        icu_din_t use_c;
        use_c = en & held;
        return (use_c & cval) | (~use_c & lvl);
    endfunction : pc_view

    // Step a word straight to a sample
    function automatic icu_ach_t step_ach(input icu_ach_t a,
                                         input icu_aword_t v,
                                         input logic [`ICU_SCODE_W-1:0] k);
        icu_ach_t r;
        r      = a;
        r.filt = v;
        r.seed = v;
        r.fill = '0;
        r.sum  = seed_sum(v, k);
        return r;
    endfunction : step_ach

    // Moving average of the latest samples
    function automatic icu_ach_t avg_ach(input icu_ach_t a,
                                        input icu_aword_t v,
                                        input icu_aword_t hist,
                                        input logic [`ICU_SCODE_W-1:0] k);
        icu_ach_t               r;
        logic [`ICU_FILL_W-1:0] n;
        icu_aword_t             oldest;
        logic [`ICU_SUM_W-1:0]  nsum;
        r      = a;
        n      = `ICU_FILL_W'(1) << k;
        oldest = (a.fill < n) ? a.seed : hist;
        nsum   = a.sum - `ICU_SUM_W'(oldest) + `ICU_SUM_W'(v);
        r.sum  = nsum;
        r.filt = `ICU_AW'(nsum >> k);
        if (a.fill < n) begin
            r.fill = a.fill + `ICU_FILL_W'(1);
        end
        return r;
    endfunction : avg_ach

    // History slot of the oldest sample
    function automatic logic [`ICU_MEM_AW-1:0] hist_raddr(input logic [`ICU_ACH_W-1:0] ch,
                                                          input logic [`ICU_HPTR_W-1:0] ptr,
                                                          input logic [`ICU_SCODE_W-1:0] k);
        logic [`ICU_HPTR_W-1:0] back;
        back = `ICU_HPTR_W'(`ICU_FILL_W'(1) << k);
        return {ch, ptr - back};
    endfunction : hist_raddr

    // Filtered words as one image
    function automatic icu_aimg_t ach_image(input icu_ach_t [`ICU_NAN-1:0] a);
        icu_aimg_t r;
        for (int c = 0; c < `ICU_NAN; c++) begin
            r[c] = a[c].filt;
        end
        return r;
    endfunction : ach_image

    // Reset release
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    icu_hist_mem u_hist (
        .clk     (REF_CLK),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (q.cur_data),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    always_comb begin
        logic [`ICU_DCNT_W-1:0]  lim;
        logic [`ICU_SCODE_W-1:0] k;
        logic                    big;
        icu_din_t                hit;
        icu_din_t                sampled;
        lim     = '0;
        k       = clamp_k(q.cfg.scode);
        big     = abs_diff(q.cur_data, q.ach[q.cur_ch].filt) > q.cfg.deadband; // [RL14] [RL15] [RL13]
        hit     = pc_hit(q.cfg.pc_en, q.latched, q.filt, q.image);              // [RL9] [RL7] [RL6]
        sampled = '0;
        d       = q;

        // Pin synchroniser
        d.s1  = DIN;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.raw = sync_agree(q.s2, q.s3, q.raw);

        // Delay filter per point
        for (int i = 0; i < `ICU_NIN; i++) begin
            lim = dly_cyc(q.cfg.dsel[i / `ICU_GRP_SZ]);          // [RL1] [RL3]
            if (q.raw[i] != q.filt[i]) begin
                if (q.cnt[i] >= lim - `ICU_DCNT_W'(1)) begin     // [RL19]
                    d.filt[i] = q.raw[i];
                    d.cnt[i]  = '0;
                end else begin
                    d.cnt[i] = q.cnt[i] + `ICU_DCNT_W'(1);
                end
            end else begin
                d.cnt[i] = '0;                                   // [RL19]
            end
        end

        // Pulse catch on the filtered level
        d.latched = q.latched | hit;
        d.cval    = (q.cval & ~hit) | (q.filt & hit);                         // [RL10]
        sampled   = pc_view(q.cfg.pc_en, q.latched, q.cval, q.filt);          // [RL8] [RL4]

        // Scan start sampling
        if (SCAN_START) begin
            d.image   = sampled;                                 // [RL17] [RL18]
            d.latched = '0;                                      // [RL20]
            d.aimg    = ach_image(q.ach);                        // [RL18]
        end

        // Configuration load
        if (CFG_LOAD) begin
            d.cfg = CFG;                                         // [RL2] [RL16]
            for (int c = 0; c < `ICU_NAN; c++) begin
                d.ach[c] = step_ach(q.ach[c], q.ach[c].filt, clamp_k(CFG.scode));
            end
        end

        // Analog filter sequencer
        unique case (q.astate)
            A_IDLE: begin
                if (AN_VALID) begin
                    d.cur_ch   = AN_CHAN;
                    d.cur_data = AN_DATA;
                    d.astate   = A_READ;
                    d.ready    = 1'b0;
                end
            end
            A_READ: begin
                d.astate = A_CALC;
            end
            A_CALC: begin
                d.astate = A_IDLE;
                d.ready  = 1'b1;
                // A load in this cycle drops the sample
                if (!CFG_LOAD) begin
                    d.ach[q.cur_ch].ptr = q.ach[q.cur_ch].ptr + `ICU_HPTR_W'(1);
                    if (!q.cfg.af_en[q.cur_ch]) begin            // [RL11]
                        d.ach[q.cur_ch] = step_ach(d.ach[q.cur_ch], q.cur_data, k);
                    end else if (big) begin                      // [RL14]
                        d.ach[q.cur_ch] = step_ach(d.ach[q.cur_ch], q.cur_data, k);
                    end else begin
                        d.ach[q.cur_ch] = avg_ach(d.ach[q.cur_ch], q.cur_data, mem_rdata, k); // [RL12] [RL13]
                    end
                end
            end
        endcase
    end

    // History access
    assign mem_we    = (q.astate == A_CALC);
    assign mem_waddr = {q.cur_ch, q.ach[q.cur_ch].ptr};
    assign mem_raddr = hist_raddr(q.cur_ch, q.ach[q.cur_ch].ptr, clamp_k(q.cfg.scode));

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            q        <= '0;
            q.cfg    <= cfg_rst();                               // [RL2] [RL16]
            q.astate <= A_IDLE;
            q.ready  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign AN_READY   = q.ready;
    assign DIN_IMAGE  = q.image;
    assign DIN_FILT   = q.filt;                                  // [RL4]
    assign HSC_RAW    = q.raw;                                   // [RL5]
    assign AN_IMAGE   = q.aimg;
    assign CFG_ACTIVE = q.cfg;
endmodule : icu_top

/* verification/icu_field.sv */
/* Field wiring model: drives the raw digital input pins.
   Assumes level and chatter are set by the bench at the falling edge. */
module icu_field
    import icu_pkg::*;
(
    input  wire logic     clk,
    input  wire icu_din_t level,
    input  wire icu_din_t noise,
    output icu_din_t      din
);
    timeunit 1ns;
    timeprecision 1ns;
    initial din = '0;
    // Chatter rides on top of the steady level
    always @(negedge clk) din <= level ^ noise;
endmodule : icu_field

/* verification/icu_chk_sva.sv */
/* Port checker of icu_top.
   Assumes a bind to icu_top and a single clock domain. */
module icu_chk
    import icu_pkg::*;
(
    input wire logic      REF_CLK,
    input wire logic      RESET_N,
    input wire icu_din_t  DIN,
    input wire logic      SCAN_START,
    input wire logic      CFG_LOAD,
    input wire icu_cfg_t  CFG,
    input wire logic      AN_VALID,
    input wire logic      AN_READY,
    input wire icu_din_t  DIN_IMAGE,
    input wire icu_din_t  DIN_FILT,
    input wire icu_din_t  HSC_RAW,
    input wire icu_aimg_t AN_IMAGE,
    input wire icu_cfg_t  CFG_ACTIVE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_take; AN_VALID && AN_READY; endsequence
    sequence s_busy; !AN_READY [*2] ##1 AN_READY; endsequence
    property p_busy; s_take |=> s_busy; endproperty
    property p_idle; AN_READY && !AN_VALID |=> AN_READY; endproperty
    property p_hsc; $stable(DIN) [*8] |=> HSC_RAW == $past(DIN); endproperty
    property p_filt; ((DIN_FILT ^ $past(DIN_FILT)) & ((DIN_FILT ^ $past(HSC_RAW))
        | ($past(HSC_RAW) ^ $past(HSC_RAW, 3)))) == '0; endproperty
    property p_img; !$past(SCAN_START) |-> $stable(DIN_IMAGE) && $stable(AN_IMAGE); endproperty
    property p_sel; SCAN_START |=> ((DIN_IMAGE ^ $past(DIN_FILT)) & ~$past(CFG_ACTIVE.pc_en)) == '0; endproperty
    property p_catch; SCAN_START |=> (($past(DIN_FILT) ^ $past(DIN_IMAGE)) & $past(CFG_ACTIVE.pc_en)
        & ~(DIN_IMAGE ^ $past(DIN_IMAGE))) == '0; endproperty
    property p_cfg; CFG_LOAD |=> CFG_ACTIVE == $past(CFG); endproperty
    a_busy: assert property (p_busy) else $error("ready low time wrong");
    a_idle: assert property (p_idle) else $error("ready dropped when idle");
    a_hsc: assert property (p_hsc) else $error("counter input not raw level");
    a_filt: assert property (p_filt) else $error("filter changed too early");
    a_img: assert property (p_img) else $error("image changed outside scan start");
    a_sel: assert property (p_sel) else $error("uncaught bit not filtered level");
    a_catch: assert property (p_catch) else $error("change lost at scan");
    a_cfg: assert property (p_cfg) else $error("config not loaded");
endmodule : icu_chk

bind icu_top icu_chk icu_chk_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .DIN(DIN), .SCAN_START(SCAN_START),
    .CFG_LOAD(CFG_LOAD), .CFG(CFG), .AN_VALID(AN_VALID), .AN_READY(AN_READY), .DIN_IMAGE(DIN_IMAGE),
    .DIN_FILT(DIN_FILT), .HSC_RAW(HSC_RAW), .AN_IMAGE(AN_IMAGE), .CFG_ACTIVE(CFG_ACTIVE));

/* verification/test_input_conditioning_unit.sv */
/* Bench of icu_top: delay filter, pulse catch, scan image, analog filter.
   Assumes icu_field drives the pins and DF_MIN_CYC of 4 cycles. */
module test_input_conditioning_unit
    import icu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {icu_din_t d; icu_aimg_t a;} icu_note_t;
    logic        ref_clk = 0, reset_n = 0, scan_start = 0, cfg_load = 0, an_valid = 0, noise_on = 0;
    logic        an_ready, scan_q = 0, h_q = 0;
    logic [1:0]  an_chan = '0;
    logic [31:0] rs = 32'h4d87f45a;
    icu_aword_t  an_data = '0;
    icu_cfg_t    cfg = '0, cfg_active;
    icu_din_t    level = '0, noise = '0, din, din_image, din_filt, hsc_raw;
    icu_aimg_t   an_image, aexp = '0;
    icu_note_t   notes[$], n;
    int          bad_count = 0, num_checks = 0, cyc = 0, flips = 0;

    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic tick(int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick
    task automatic scan(icu_din_t d);
        notes.push_back({d, aexp});
        scan_start = 1;
        tick(1);
        scan_start = 0;
    endtask : scan
    task automatic sample(logic [1:0] ch, icu_aword_t v, icu_aword_t e);
        check("an_ready", an_ready, 1'b1);
        an_chan = ch;
        an_data = v;
        an_valid = 1;
        tick(1);
        an_valid = 0;
        aexp[ch] = e;
        tick(3);
    endtask : sample

    initial forever #5 ref_clk = ~ref_clk;
    icu_top #(.DF_MIN_CYC(4)) icu_top_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .DIN(din), .SCAN_START(scan_start),
        .CFG_LOAD(cfg_load), .CFG(cfg), .AN_VALID(an_valid), .AN_CHAN(an_chan), .AN_DATA(an_data),
        .AN_READY(an_ready), .DIN_IMAGE(din_image), .DIN_FILT(din_filt), .HSC_RAW(hsc_raw),
        .AN_IMAGE(an_image), .CFG_ACTIVE(cfg_active));
    icu_field icu_field_i (.clk(ref_clk), .level(level), .noise(noise), .din(din));

    // Chatter on the slowest group only
    always @(negedge ref_clk) begin
        rs = xs(rs);
        noise <= noise_on ? rs[15:0] & 16'hf000 : '0;
    end
    // Image appears the cycle after scan start
    always @(posedge ref_clk) begin
        cyc++;
        if (hsc_raw[12] !== h_q) flips++;
        h_q = hsc_raw[12];
        if (scan_q) begin
            n = notes.pop_front();
            check("din_image", din_image, n.d);
            check("an_image", an_image, n.a);
        end
        scan_q = scan_start;
        if (cyc > 2000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        tick(5);
        reset_n = 1;
        tick(3);
        check("cfg_active", cfg_active, {12'hb6d, 16'h0000, 4'hc, 3'h4, 16'h0040});
        level = 16'h0001;
        tick(110);
        scan(16'h0000);
        tick(40);
        scan(16'h0001);
        sample(2'h0, rs[15:0], rs[15:0]);
        sample(2'h1, rs[15:0], rs[15:0]);
        sample(2'h2, 16'h1000, 16'h1000);
        sample(2'h2, 16'h1010, 16'h1001);
        sample(2'h2, 16'h1041, 16'h1005);
        sample(2'h2, 16'h0fc4, 16'h0fc4);
        sample(2'h3, 16'h2000, 16'h2000);
        sample(2'h3, 16'h2020, 16'h2002);
        scan(16'h0001);
        cfg = {12'hc88, 16'h0fff, 4'hc, 3'h4, 16'h0040};
        cfg_load = 1;
        tick(1);
        cfg_load = 0;
        noise_on = 1;
        tick(1);
        check("cfg_active", cfg_active, cfg);
        level = 16'h0ff1;
        tick(12);
        level = 16'h0001;
        tick(30);
        scan(16'h00f1);
        tick(2);
        scan(16'h0001);
        level = 16'h0000;
        tick(6);
        level = 16'h0001;
        tick(20);
        scan(16'h0000);
        tick(2);
        level = 16'h0000;
        tick(6);
        level = 16'h0001;
        tick(20);
        scan(16'h0001);
        tick(300);
        scan(16'h0001);
        tick(3);
        check("hsc_flips", flips > 20, 1'b1);
        check("din_filt", din_filt, 16'h0001);
        check("hsc_raw", hsc_raw[11:0], 12'h001);
        print_verdict();
    end
endmodule : test_input_conditioning_unit
